// ===== core/rdburst_pkg.sv
/*
 * Shared constants and carriers of the read burst control block.
 * Assumes a system clock of 125 MHz and a link clock from the host.
 */
`default_nettype none
package rdburst_pkg;
    // ------------------------------------------------------------
    // Widths and register map.
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int BANK_W = 4;
    localparam int COL_W = 10;
    localparam int LAT_W = 6;
    localparam logic [7:0] MODE_OFS = 8'h00;
    localparam logic [7:0] LAT_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    localparam int LAT_ADD_LSB = 0;
    localparam int LAT_CAS_LSB = 8;
    localparam int LAT_PRE_BIT = 16;
    localparam int STAT_AP_LSB = 8;
    localparam int STAT_ERR_BIT = 16;
    localparam int STAT_CHOP_BIT = 17;
    localparam int CLR_BIT = 0;
    // ------------------------------------------------------------
    // Burst field codes and reset values.
    // ------------------------------------------------------------
    localparam logic [1:0] BURST_FIXED8 = 2'h0;
    localparam logic [1:0] BURST_PER_CMD = 2'h1;
    localparam logic [1:0] BURST_FIXED4 = 2'h2;
    localparam logic [1:0] MODE_RST = BURST_FIXED8;
    localparam logic [4:0] ADD_LAT_RST = 5'h00;
    localparam logic [4:0] CAS_LAT_RST = 5'h0b;
    // Data clocks of a burst: two beats per clock.
    localparam logic [2:0] FULL_CLKS = 3'h4;
    localparam logic [2:0] CHOP_CLKS = 3'h2;
    // ------------------------------------------------------------
    // Timing.
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    localparam int RTP_MIN_PS = 7500;
    localparam int RTP_MIN_NCK = 4;
    localparam int RTP_TIME_CYC = (RTP_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RTP_CYC = (RTP_TIME_CYC > RTP_MIN_NCK) ? RTP_TIME_CYC : RTP_MIN_NCK;
    localparam logic [2:0] CCD_FORBID_2PRE = 3'h5;
    // ------------------------------------------------------------
    // Carriers.
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] burst_mode;
        logic pre_two;
        logic [4:0] add_lat;
        logic [4:0] cas_lat;
        logic clr_tog;
    } cfg_s;
    typedef struct packed {
        logic [7:0] rd_cnt;
        logic [7:0] ap_cnt;
        logic spacing_err;
        logic last_chop;
    } stat_s;
    typedef struct packed {
        logic valid;
        logic chop;
        logic ap;
        logic [BANK_W-1:0] bank;
        logic [COL_W-1:0] col;
    } cmd_s;
    localparam cfg_s CFG_RST = '{MODE_RST, 1'b0, ADD_LAT_RST, CAS_LAT_RST, 1'b0};
endpackage
`default_nettype wire

// ===== core/cdc_word.sv
/*
 * Carries a word from one clock domain to another by a toggle handshake.
 * Assumes the word may change at any time; the copy is refreshed continually.
 */
`timescale 1ns/10ps
`default_nettype none
module cdc_word #(
    parameter int W = 8,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic src_clk, // Source clock.
    input wire logic src_rstn, // Source reset, active low.
    input wire logic [W-1:0] src_data, // Word to carry.
    input wire logic dst_clk, // Destination clock.
    input wire logic dst_rstn, // Destination reset, active low.
    output logic [W-1:0] dst_data // Carried copy.
);
    logic req_q, req_d; // Request toggle.
    logic [W-1:0] hold_q, hold_d; // Word held stable while in flight.
    logic [1:0] ack_sync_q; // Acknowledge synchroniser.
    logic [1:0] req_sync_q; // Request synchroniser.
    logic ack_q, ack_d; // Acknowledge toggle.
    logic [W-1:0] dst_d; // Next copy.

    // ------------------------------------------------------------
    // Source side.
    // ------------------------------------------------------------
    // A new word is latched only once the previous one is acknowledged.
    always_comb begin
        req_d = req_q;
        hold_d = hold_q;
        if (ack_sync_q[1] == req_q) begin
            hold_d = src_data;
            req_d = ~req_q;
        end
    end

    // Source registers.
    always_ff @(posedge src_clk or negedge src_rstn) begin
        if (!src_rstn) begin
            req_q <= 1'b0;
            hold_q <= RST;
            ack_sync_q <= 2'h0;
        end else begin
            req_q <= req_d;
            hold_q <= hold_d;
            ack_sync_q <= {ack_sync_q[0], ack_q};
        end
    end

    // ------------------------------------------------------------
    // Destination side.
    // ------------------------------------------------------------
    // The held word is stable by the time the request toggle arrives.
    always_comb begin
        ack_d = ack_q;
        dst_d = dst_data;
        if (req_sync_q[1] != ack_q) begin
            dst_d = hold_q;
            ack_d = req_sync_q[1];
        end
    end

    // Destination registers.
    always_ff @(posedge dst_clk or negedge dst_rstn) begin
        if (!dst_rstn) begin
            ack_q <= 1'b0;
            dst_data <= RST;
            req_sync_q <= 2'h0;
        end else begin
            ack_q <= ack_d;
            dst_data <= dst_d;
            req_sync_q <= {req_sync_q[0], req_q};
        end
    end
endmodule
`default_nettype wire

// ===== core/read_pipe.sv
/*
 * Delay line for read commands with several taps of chosen delay.
 * Assumes tap delays never exceed the depth; delay zero is the input.
 */
`timescale 1ns/10ps
`default_nettype none
module read_pipe #(
    parameter int W = 8,
    parameter int DEPTH = 63,
    parameter int NTAP = 3,
    parameter int IW = 6
) (
    input wire logic clk, // Clock.
    input wire logic rstn, // Reset, active low.
    input wire logic [W-1:0] d, // Word entering the line.
    input wire logic [NTAP-1:0][IW-1:0] tap_dly, // Delay of each tap.
    output logic [NTAP-1:0][W-1:0] tap_q // Word seen at each tap.
);
    logic [W-1:0] sr_q [DEPTH]; // Stage i holds the word from i+1 clocks ago.
    logic [W-1:0] sr_d [DEPTH]; // Next stage contents.

    // Shift one stage per clock.
    always_comb begin
        sr_d[0] = d;
        for (int i = 1; i < DEPTH; i++) begin
            sr_d[i] = sr_q[i-1];
        end
    end

    // Stage registers.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < DEPTH; i++) begin
                sr_q[i] <= '0;
            end
        end else begin
            sr_q <= sr_d;
        end
    end

    // Each tap picks the stage of its delay.
    for (genvar k = 0; k < NTAP; k++) begin : g_tap
        assign tap_q[k] = (tap_dly[k] == '0) ? d : sr_q[tap_dly[k] - IW'(1)];
    end
endmodule
`default_nettype wire

// ===== core/read_burst_ctrl.sv
/*
 * Read command handling of a synchronous DRAM: burst length choice,
 * read latency, data and strobe timing, and automatic close of the bank.
 * Assumes the host drives commands on link_clk and software sets the
 * mode over a plain register port on clk.
 */
// Our own choices: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module read_burst_ctrl (
    input wire logic clk, // System clock.
    input wire logic rstn, // Reset, active low.
    input wire logic [rdburst_pkg::ADDR_W-1:0] addr, // Register address.
    input wire logic [rdburst_pkg::DATA_W-1:0] wdata, // Write data.
    input wire logic wr, // Write strobe.
    input wire logic rd, // Read strobe.
    output logic [rdburst_pkg::DATA_W-1:0] rdata, // Read data.
    input wire logic link_clk, // Link clock from the host.
    input wire logic cmd_read, // Read command.
    input wire logic burst_select_addr_bit, // Per-command length.
    input wire logic autoprecharge_addr_bit, // Close bank after read.
    input wire logic [rdburst_pkg::BANK_W-1:0] cmd_bank, // Bank.
    input wire logic [rdburst_pkg::COL_W-1:0] cmd_col, // Column.
    output logic [rdburst_pkg::COL_W-1:0] dq_rise, // Beat on rising edge.
    output logic [rdburst_pkg::COL_W-1:0] dq_fall, // Beat on falling edge.
    output logic dq_oe, // Data driven.
    output logic strobe_oe, // Strobe driven.
    output logic strobe_run, // Strobe toggling.
    output logic precharge_start, // Precharge begins.
    output logic [rdburst_pkg::BANK_W-1:0] precharge_bank // Bank closed.
);
    import rdburst_pkg::*;

    // ------------------------------------------------------------
    // Resets.
    // ------------------------------------------------------------
    logic [1:0] rst_sync_q; // System reset release.
    logic [1:0] lrst_sync_q; // Link reset release.
    logic srstn; // Released system reset.
    logic lrstn; // Released link reset.

    // Release the reset in each domain through two flops.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    // Link side release.
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            lrst_sync_q <= 2'h0;
        end else begin
            lrst_sync_q <= {lrst_sync_q[0], 1'b1};
        end
    end
    assign srstn = rst_sync_q[1];
    assign lrstn = lrst_sync_q[1];

    // ------------------------------------------------------------
    // Register port.
    // ------------------------------------------------------------
    cfg_s cfg_q, cfg_d; // Software settings.
    stat_s sstat; // Status seen in the system domain.
    logic [DATA_W-1:0] rdata_d; // Next read data.

    // Writes update the settings; reads answer one clock later.
    always_comb begin
        cfg_d = cfg_q;
        rdata_d = '0;
        if (wr && addr == MODE_OFS) begin
            cfg_d.burst_mode = wdata[1:0];
        end
        if (wr && addr == LAT_OFS) begin
            cfg_d.add_lat = wdata[LAT_ADD_LSB +: 5];
            cfg_d.cas_lat = wdata[LAT_CAS_LSB +: 5];
            cfg_d.pre_two = wdata[LAT_PRE_BIT];
        end
        if (wr && addr == STAT_OFS && wdata[CLR_BIT]) begin
            cfg_d.clr_tog = ~cfg_q.clr_tog;
        end
        if (rd) begin
            unique case (addr)
                MODE_OFS: rdata_d = {30'h0, cfg_q.burst_mode};
                LAT_OFS: rdata_d = {15'h0, cfg_q.pre_two, 3'h0, cfg_q.cas_lat, 3'h0, cfg_q.add_lat};
                STAT_OFS: rdata_d = {14'h0, sstat.last_chop, sstat.spacing_err,
                                     sstat.ap_cnt, sstat.rd_cnt};
                default: rdata_d = '0;
            endcase
        end
    end

    // Register port flops.
    always_ff @(posedge clk or negedge srstn) begin
        if (!srstn) begin
            cfg_q <= CFG_RST;
            rdata <= '0;
        end else begin
            cfg_q <= cfg_d;
            rdata <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Crossings.
    // ------------------------------------------------------------
    cfg_s lcfg; // Settings in the link domain.
    stat_s lstat_q, lstat_d; // Status kept in the link domain.

    cdc_word #(.W($bits(cfg_s)), .RST(CFG_RST)) u_cfg_cdc (
        .src_clk(clk),
        .src_rstn(srstn),
        .src_data(cfg_q),
        .dst_clk(link_clk),
        .dst_rstn(lrstn),
        .dst_data(lcfg)
    );

    cdc_word #(.W($bits(stat_s))) u_stat_cdc (
        .src_clk(link_clk),
        .src_rstn(lrstn),
        .src_data(lstat_q),
        .dst_clk(clk),
        .dst_rstn(srstn),
        .dst_data(sstat)
    );

    // ------------------------------------------------------------
    // Command capture and delay.
    // ------------------------------------------------------------
    // Decide whether a command is chopped from the burst field.
    function automatic logic burst_is_chop(input logic [1:0] mode, input logic sel);
        logic chop;
        chop = 1'b0;
        if (mode == BURST_FIXED4) begin
            chop = 1'b1;
        end else if (mode == BURST_PER_CMD) begin
            chop = ~sel;
        end
        return chop;
    endfunction

    cmd_s cmd_q, cmd_d; // Captured command.
    logic [LAT_W-1:0] rd_lat; // Read latency in link clocks.
    logic [LAT_W-1:0] pre_dly; // Delay to the strobe preamble.
    logic [2:0][LAT_W-1:0] taps; // Internal read point, preamble, data.
    cmd_s [2:0] tap_cmd; // Commands seen at the taps.

    // Latency is additive plus cas latency.
    always_comb begin
        rd_lat = LAT_W'({1'b0, lcfg.add_lat} + {1'b0, lcfg.cas_lat});
        pre_dly = (rd_lat > (lcfg.pre_two ? 6'h2 : 6'h1))
                  ? rd_lat - (lcfg.pre_two ? 6'h2 : 6'h1) : 6'h0;
        taps = {rd_lat, pre_dly, LAT_W'(lcfg.add_lat)};
        cmd_d.valid = cmd_read;
        cmd_d.chop = burst_is_chop(lcfg.burst_mode, burst_select_addr_bit);
        cmd_d.ap = autoprecharge_addr_bit;
        cmd_d.bank = cmd_bank;
        cmd_d.col = cmd_col;
    end

    read_pipe #(.W($bits(cmd_s)), .DEPTH(63), .NTAP(3), .IW(LAT_W)) u_pipe (
        .clk(link_clk),
        .rstn(lrstn),
        .d(cmd_q),
        .tap_dly(taps),
        .tap_q(tap_cmd)
    );

    // ------------------------------------------------------------
    // Burst engine.
    // ------------------------------------------------------------
    logic [2:0] left_q, left_d; // Data clocks still to send.
    logic [2:0] beat_q, beat_d; // Data clock within the burst.
    logic [COL_W-1:0] col_q, col_d; // Start column.
    logic chop_q, chop_d; // Current burst is chopped.
    logic pre_q, pre_d; // Preamble running.
    logic dat_start; // Data of a command starts.
    logic [2:0] gap_q, gap_d; // Clocks since the last read, less one.
    logic [6:0] ap_cnt_q, ap_cnt_d; // Countdown to automatic precharge.
    logic [BANK_W-1:0] ap_bank_q, ap_bank_d; // Bank to close.
    logic clr_seen_q; // Last clear toggle seen.

    // Next burst, strobe, precharge and status state.
    always_comb begin
        dat_start = tap_cmd[2].valid;
        left_d = (left_q != 3'h0) ? left_q - 3'h1 : 3'h0;
        beat_d = beat_q + 3'h1;
        col_d = col_q;
        chop_d = chop_q;
        if (dat_start) begin
            // A chopped burst sends two clocks of data only.
            left_d = tap_cmd[2].chop ? CHOP_CLKS : FULL_CLKS;
            beat_d = 3'h0;
            col_d = tap_cmd[2].col;
            chop_d = tap_cmd[2].chop;
        end
        pre_d = tap_cmd[1].valid | (pre_q & ~dat_start);
        gap_d = cmd_q.valid ? 3'h0 : ((gap_q == 3'h7) ? 3'h7 : gap_q + 3'h1);
        ap_cnt_d = (ap_cnt_q != 7'h0) ? ap_cnt_q - 7'h1 : 7'h0;
        ap_bank_d = ap_bank_q;
        // The precharge waits for the read-to-precharge time and the burst.
        if (tap_cmd[0].valid && tap_cmd[0].ap) begin
            ap_cnt_d = ((7'(lcfg.cas_lat) + 7'(tap_cmd[0].chop ? CHOP_CLKS : FULL_CLKS) + 7'h1)
                        > 7'(RTP_CYC))
                       ? 7'(lcfg.cas_lat) + 7'(tap_cmd[0].chop ? CHOP_CLKS : FULL_CLKS)
                       : 7'(RTP_CYC - 1);
            ap_bank_d = tap_cmd[0].bank;
        end
        lstat_d = lstat_q;
        if (clr_seen_q != lcfg.clr_tog) begin
            lstat_d = '0;
        end
        lstat_d.rd_cnt = lstat_d.rd_cnt + 8'(cmd_q.valid);
        lstat_d.ap_cnt = lstat_d.ap_cnt + 8'(ap_cnt_q == 7'h1);
        if (cmd_q.valid) begin
            lstat_d.last_chop = cmd_q.chop;
        end
        // A read five clocks after another is flagged in two-clock mode.
        if (cmd_q.valid && lcfg.pre_two && gap_q == CCD_FORBID_2PRE - 3'h1) begin
            lstat_d.spacing_err = 1'b1;
        end
    end

    // Link domain registers, outputs included.
    always_ff @(posedge link_clk or negedge lrstn) begin
        if (!lrstn) begin
            cmd_q <= '0;
            left_q <= 3'h0;
            beat_q <= 3'h0;
            col_q <= '0;
            chop_q <= 1'b0;
            pre_q <= 1'b0;
            gap_q <= 3'h7;
            ap_cnt_q <= 7'h0;
            ap_bank_q <= '0;
            lstat_q <= '0;
            clr_seen_q <= 1'b0;
            dq_rise <= '0;
            dq_fall <= '0;
            dq_oe <= 1'b0;
            strobe_oe <= 1'b0;
            strobe_run <= 1'b0;
            precharge_start <= 1'b0;
            precharge_bank <= '0;
        end else begin
            cmd_q <= cmd_d;
            left_q <= left_d;
            beat_q <= beat_d;
            col_q <= col_d;
            chop_q <= chop_d;
            pre_q <= pre_d;
            gap_q <= gap_d;
            ap_cnt_q <= ap_cnt_d;
            ap_bank_q <= ap_bank_d;
            lstat_q <= lstat_d;
            clr_seen_q <= lcfg.clr_tog;
            dq_rise <= col_d + COL_W'({beat_d, 1'b0});
            dq_fall <= col_d + COL_W'({beat_d, 1'b1});
            dq_oe <= (left_d != 3'h0);
            // Back-to-back bursts keep the strobe running with no gap.
            strobe_oe <= pre_d | (left_d != 3'h0) | (left_q == 3'h1);
            strobe_run <= (left_d != 3'h0);
            precharge_start <= (ap_cnt_q == 7'h1);
            precharge_bank <= ap_bank_q;
        end
    end

    // ------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------
    property p_full_len;
        @(posedge link_clk) disable iff (!lrstn)
        $rose(dq_oe) && !chop_q |-> dq_oe [*4];
    endproperty
    a_full_len: assert property (p_full_len) else $error("full burst short");

    property p_chop_len;
        @(posedge link_clk) disable iff (!lrstn)
        $rose(dq_oe) && chop_q |-> dq_oe ##1 dq_oe ##1 (!dq_oe || $past(dat_start));
    endproperty
    a_chop_len: assert property (p_chop_len) else $error("chop burst length");

    property p_fixed4;
        @(posedge link_clk) disable iff (!lrstn)
        cmd_read && lcfg.burst_mode == BURST_FIXED4 |=> cmd_q.chop;
    endproperty
    a_fixed4: assert property (p_fixed4) else $error("fixed four not chopped");

    property p_select;
        @(posedge link_clk) disable iff (!lrstn)
        cmd_read && lcfg.burst_mode == BURST_PER_CMD |=> cmd_q.chop != $past(burst_select_addr_bit);
    endproperty
    a_select: assert property (p_select) else $error("per-command choice lost");

    property p_rtp_min;
        @(posedge link_clk) disable iff (!lrstn)
        tap_cmd[0].valid && tap_cmd[0].ap |=> !precharge_start [*3];
    endproperty
    a_rtp_min: assert property (p_rtp_min) else $error("precharge too early");

    property p_ap_fires;
        @(posedge link_clk) disable iff (!lrstn)
        tap_cmd[0].valid && tap_cmd[0].ap |-> ##[4:40] precharge_start;
    endproperty
    a_ap_fires: assert property (p_ap_fires) else $error("no automatic precharge");

    property p_no_ap;
        @(posedge link_clk) disable iff (!lrstn)
        precharge_start |-> $past(ap_cnt_q) == 7'h1;
    endproperty
    a_no_ap: assert property (p_no_ap) else $error("stray precharge");

    property p_b2b;
        @(posedge link_clk) disable iff (!lrstn)
        left_q == 3'h1 && dat_start |=> dq_oe && strobe_oe;
    endproperty
    a_b2b: assert property (p_b2b) else $error("gap between bursts");

    property p_preamble;
        @(posedge link_clk) disable iff (!lrstn)
        $rose(dq_oe) |-> $past(strobe_oe);
    endproperty
    a_preamble: assert property (p_preamble) else $error("no preamble");

    property p_spacing;
        @(posedge link_clk) disable iff (!lrstn)
        cmd_q.valid && lcfg.pre_two && gap_q == 3'h4 |=> lstat_q.spacing_err;
    endproperty
    a_spacing: assert property (p_spacing) else $error("spacing not flagged");
endmodule
`default_nettype wire

// ===== tb/host_cmd_model.sv
/*
 * Host model: makes the free-running link clock and drives read commands.
 * Assumes the bench spaces its calls of issue() as a memory controller must, save the two reads of t_spacing, five apart in two-clock preamble mode.
 */
`timescale 1ns/10ps
`default_nettype none
module host_cmd_model (
    output logic link_clk, // Link clock, free running.
    output logic cmd_read, // Read command.
    output logic bsel, // Per-command length bit.
    output logic apre, // Auto-close bit.
    output logic [rdburst_pkg::BANK_W-1:0] bank, // Bank.
    output logic [rdburst_pkg::COL_W-1:0] col // Column.
);
    // Clock starts off phase with the system clock.
    initial begin
        link_clk = 1'b0;
        {cmd_read, bsel, apre, bank, col} = '0;
        #13;
        forever #40 link_clk = ~link_clk;
    end
    // One read taken at the next edge; address lines flip once idle.
    // Reads are at least four apart, five apart in two-clock preamble mode only in t_spacing, and no writes follow.
    task automatic issue(input logic c8, input logic ap, input logic [3:0] b, input logic [9:0] c);
        @(posedge link_clk);
        cmd_read <= 1'b1;
        bsel <= c8;
        apre <= ap;
        bank <= b;
        col <= c;
        @(posedge link_clk);
        cmd_read <= 1'b0;
        bsel <= ~c8;
        apre <= ~ap;
        bank <= ~b;
        col <= ~c;
    endtask
endmodule
`default_nettype wire

// ===== tb/read_burst_ctrl_test.sv
/*
 * Self-checking bench of the read burst control block.
 * Assumes the host model in host_cmd_model.sv and the design package.
 */
`timescale 1ns/10ps
`default_nettype none
module read_burst_ctrl_test;
    import rdburst_pkg::*;
    logic clk, rstn, wr, rd, cmd_read, bsel, apre, link_clk;
    logic dq_oe, strobe_oe, strobe_run, precharge_start;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, s;
    logic [BANK_W-1:0] bank, precharge_bank, pb;
    logic [COL_W-1:0] col, dq_rise, dq_fall, b1, f1, b5;
    int n_fail, checks, first, len, slen, pt, pc, rn;
    // System clock of 8 ns.
    always #4 clk = ~clk;
    host_cmd_model host(.link_clk(link_clk), .cmd_read(cmd_read), .bsel(bsel), .apre(apre),
        .bank(bank), .col(col));
    read_burst_ctrl uut(.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .link_clk(link_clk), .cmd_read(cmd_read), .burst_select_addr_bit(bsel),
        .autoprecharge_addr_bit(apre), .cmd_bank(bank), .cmd_col(col), .dq_rise(dq_rise),
        .dq_fall(dq_fall), .dq_oe(dq_oe), .strobe_oe(strobe_oe), .strobe_run(strobe_run),
        .precharge_start(precharge_start), .precharge_bank(precharge_bank));
    // Compares and counts.
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic rreg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // Mode, latencies and preamble, then time for them to cross.
    task automatic cfg(input logic [1:0] m, input logic [4:0] add_l, input logic [4:0] cas_l,
        input logic pre);
        wreg(MODE_OFS, {30'h0, m});
        wreg(LAT_OFS, {15'h0, pre, 3'h0, cas_l, 3'h0, add_l});
        repeat (20) @(posedge link_clk);
    endtask
    // Watches 48 link clocks: data window, strobe window and precharge.
    task automatic watch();
        first = 0;
        len = 0;
        slen = 0;
        pc = 0;
        pt = 0;
        rn = 0;
        for (int i = 1; i <= 48; i++) begin
            @(posedge link_clk);
            #1;
            if (strobe_oe === 1'b1) slen++;
            if (strobe_run === 1'b1) rn++;
            if (dq_oe === 1'b1) begin
                len++;
                if (len == 1) begin
                    first = i;
                    b1 = dq_rise;
                    f1 = dq_fall;
                end
                if (len == 5) b5 = dq_rise;
            end
            if (precharge_start === 1'b1) begin
                pc++;
                pt = i;
                pb = precharge_bank;
            end
        end
    endtask
    task automatic t_fixed8();
        cfg(BURST_FIXED8, 5'h00, 5'h0b, 1'b0);
        host.issue(1'b0, 1'b0, 4'h3, 10'h040);
        watch();
        // Latency of eleven plus the output flop, counted from the clock after the command.
        chk("latency", first, 12);
        chk("data clocks", len, 4);
        chk("strobe clocks", slen, 6);
        chk("strobe run", rn, 4);
        chk("beat0", b1, 10'h040);
        chk("beat1", f1, 10'h041);
        chk("no close", pc, 0);
        $display("test fixed8 done");
    endtask
    task automatic t_fixed4();
        cfg(BURST_FIXED4, 5'h00, 5'h0b, 1'b0);
        host.issue(1'b1, 1'b1, 4'h5, 10'h080);
        watch();
        chk("data clocks", len, 2);
        chk("strobe clocks", slen, 4);
        chk("close count", pc, 1);
        chk("close bank", pb, 4'h5);
        chk("strobe run", rn, 2);
        chk("close after burst", pt >= first + len, 1);
        $display("test fixed4 done");
    endtask
    task automatic t_percmd();
        cfg(BURST_PER_CMD, 5'h03, 5'h0b, 1'b1);
        host.issue(1'b1, 1'b0, 4'h1, 10'h100);
        repeat (2) @(posedge link_clk);
        host.issue(1'b0, 1'b1, 4'h9, 10'h200);
        watch();
        // Latency of fourteen plus the output flop, watched from four clocks later.
        chk("latency", first, 11);
        chk("data clocks", len, 6);
        chk("first burst", b1, 10'h100);
        chk("second burst", b5, 10'h200);
        chk("strobe clocks", slen, 9);
        chk("close bank", pb, 4'h9);
        $display("test per command done");
    endtask
    task automatic t_spacing();
        cfg(BURST_PER_CMD, 5'h00, 5'h0b, 1'b1);
        wreg(STAT_OFS, 32'h1);
        // The clear crosses to the link side and the status crosses back.
        repeat (20) @(posedge link_clk);
        rreg(STAT_OFS, s);
        chk("cleared", s, 32'h0);
        host.issue(1'b1, 1'b1, 4'h2, 10'h010);
        repeat (3) @(posedge link_clk);
        host.issue(1'b1, 1'b0, 4'h6, 10'h020);
        watch();
        rreg(STAT_OFS, s);
        chk("status", s, 32'h0001_0102);
        rreg(8'h0c, s);
        chk("unmapped", s, 32'h0);
        rreg(MODE_OFS, s);
        chk("mode", s, 32'h1);
        $display("test spacing done");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Main sequence: reset over five slow clocks, then the tests.
    initial begin
        {clk, rstn, wr, rd} = '0;
        addr = '0;
        wdata = '0;
        n_fail = 0;
        checks = 0;
        repeat (5) @(posedge link_clk);
        rstn <= 1'b1;
        repeat (12) @(posedge link_clk);
        t_fixed8();
        t_fixed4();
        t_percmd();
        t_spacing();
        finish_test();
    end
    // Watchdog well beyond the 26 us the tests need.
    initial begin
        #200000;
        n_fail++;
        finish_test();
    end
endmodule
`default_nettype wire
